// *** include/ssm_pkg.sv ***
package ssm_pkg;
   // word and divider widths
   localparam int WORD_W = 8;
   localparam int DIV_W = 16;
   localparam int EDGE_W = 5;
   // system clock and the cpu half-period it represents
   localparam int CLK_PERIOD_NS = 10;
   localparam int CPU_HALF_PERIOD_NS = CLK_PERIOD_NS / 2;
   // serial period = 4 cpu half-periods x (divider + 1)
   localparam int HALF_PERIODS_PER_STEP = 4;
   localparam int CYC_PER_STEP = HALF_PERIODS_PER_STEP * CPU_HALF_PERIOD_NS / CLK_PERIOD_NS;
   // fastest allowed serial period, rounded up to whole cycles
   localparam int MIN_SCLK_PERIOD_NS = 125;
   localparam int MIN_SCLK_CYC = (MIN_SCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_STEPS = (MIN_SCLK_CYC + CYC_PER_STEP - 1) / CYC_PER_STEP;
   localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(MIN_STEPS - 1);
   // two serial clock edges per bit
   localparam logic [EDGE_W-1:0] EDGES = EDGE_W'(2 * WORD_W);
   // reset values
   localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RST = 16'hffff;

   typedef enum logic [1:0] {
      SSM_IDLE = 2'b00,
      SSM_RUN = 2'b01,
      SSM_DONE = 2'b10
   } ssm_state_t;
endpackage

// *** include/ssm_stream_if.sv ***
`timescale 1ns/1ps
interface ssm_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// *** hw/ssm_fifo2.sv ***
`timescale 1ns/1ps
module ssm_fifo2 (
   input wire logic clock,
   input wire logic sys_rst,
   ssm_stream_if.snk push,
   ssm_stream_if.src pop
);
   logic [ssm_pkg::WORD_W-1:0] head_r, head_nxt, tail_r, tail_nxt;
   logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt, in_rdy_r, in_rdy_nxt;
   logic take, give;

   assign take = push.valid & in_rdy_r;
   assign give = head_v_r & pop.ready;
   assign push.ready = in_rdy_r;
   assign pop.valid = head_v_r;
   assign pop.data = head_r;

   // head is the output slot; tail catches a word while the reader stalls
   always_comb begin
      head_nxt = head_r;
      tail_nxt = tail_r;
      head_v_nxt = head_v_r & ~give;
      tail_v_nxt = tail_v_r;
      if (!head_v_nxt && tail_v_nxt) begin
         head_v_nxt = 1'b1;
         head_nxt = tail_r;
         tail_v_nxt = 1'b0;
      end
      if (take) begin
         if (!head_v_nxt) begin
            head_v_nxt = 1'b1;
            head_nxt = push.data;
         end else begin
            tail_v_nxt = 1'b1;
            tail_nxt = push.data;
         end
      end
      in_rdy_nxt = ~tail_v_nxt; // ready is registered from the next tail state, so full shows in the same cycle as the tail
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         head_r <= ssm_pkg::WORD_RST;
         tail_r <= ssm_pkg::WORD_RST;
         head_v_r <= 1'b0;
         tail_v_r <= 1'b0;
         in_rdy_r <= 1'b1;
      end else begin
         head_r <= head_nxt;
         tail_r <= tail_nxt;
         head_v_r <= head_v_nxt;
         tail_v_r <= tail_v_nxt;
         in_rdy_r <= in_rdy_nxt;
      end
   end

   a_fifo_hold_data: assert property (@(posedge clock) disable iff (sys_rst)
      head_v_r && !pop.ready |=> head_v_r && $stable(head_r))
      else $error("fifo output changed while stalled");
   a_fifo_full_block: assert property (@(posedge clock) disable iff (sys_rst)
      tail_v_r |-> !in_rdy_r)
      else $error("fifo ready while full");
   c_fifo_full: cover property (@(posedge clock) disable iff (sys_rst) head_v_r && tail_v_r);
endmodule

// *** hw/ssm_master.sv ***
`timescale 1ns/1ps
module ssm_master (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] baud_divider,
   input wire logic clock_phase_select,
   input wire logic clock_polarity_select,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic serial_clk,
   output logic serial_data_out,
   input wire logic serial_data_in,
   output logic busy,
   output logic rate_clamped
);
   localparam int W = ssm_pkg::WORD_W;

   ssm_stream_if #(.W(W)) rx_push ();
   ssm_stream_if #(.W(W)) rx_pop ();

   ssm_pkg::ssm_state_t state_r, state_nxt;
   logic [ssm_pkg::DIV_W-1:0] div_r, div_nxt, cnt_r, cnt_nxt;
   logic [ssm_pkg::EDGE_W-1:0] edge_r, edge_nxt;
   logic [W-1:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
   logic pha_r, pha_nxt, pol_r, pol_nxt;
   logic sclk_r, sclk_nxt, dout_r, dout_nxt;
   logic tx_rdy_r, tx_rdy_nxt, clamp_r, clamp_nxt, busy_r, busy_nxt;
   logic start, edge_p, leading, shift_e, latch_e;

   // clamp the divider so the serial period never drops under the floor
   function automatic logic [ssm_pkg::DIV_W-1:0] safe_div(input logic [ssm_pkg::DIV_W-1:0] d);
      safe_div = (d < ssm_pkg::DIV_MIN) ? ssm_pkg::DIV_MIN : d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // edge timing
   ////////////////////////////////////////////////////////////////////////////

   // one-cycle enable every half serial period (div+1 cycles)
   assign start = (state_r == ssm_pkg::SSM_IDLE) & tx_valid & tx_rdy_r;
   assign edge_p = (state_r == ssm_pkg::SSM_RUN) & (cnt_r == div_r);
   assign leading = ~edge_r[0];
   assign shift_e = edge_p & (leading ^ pha_r);
   assign latch_e = edge_p & ~(leading ^ pha_r);

   ////////////////////////////////////////////////////////////////////////////
   // transfer sequencer
   ////////////////////////////////////////////////////////////////////////////

   // next-state logic for the whole transfer
   always_comb begin
      state_nxt = state_r;
      div_nxt = div_r;
      cnt_nxt = cnt_r;
      edge_nxt = edge_r;
      tx_sh_nxt = tx_sh_r;
      rx_sh_nxt = rx_sh_r;
      pha_nxt = pha_r;
      pol_nxt = pol_r;
      sclk_nxt = sclk_r;
      dout_nxt = dout_r;
      clamp_nxt = clamp_r;
      rx_push.valid = 1'b0;
      rx_push.data = rx_sh_r;
      case (state_r)
         ssm_pkg::SSM_IDLE: begin
            sclk_nxt = clock_polarity_select;
            // phase select is frozen in pha_r at start
            pol_nxt = clock_polarity_select;
            if (start) begin
               // settings are frozen for the whole word
               div_nxt = safe_div(baud_divider);
               clamp_nxt = (baud_divider < ssm_pkg::DIV_MIN);
               pha_nxt = clock_phase_select;
               cnt_nxt = '0;
               edge_nxt = '0;
               tx_sh_nxt = tx_data;
               if (clock_phase_select) begin
                  // late shift: first bit must stand before the first latch edge
                  dout_nxt = tx_data[W-1];
               end
               state_nxt = ssm_pkg::SSM_RUN;
            end
         end
         ssm_pkg::SSM_RUN: begin
            cnt_nxt = cnt_r + 16'h0001;
            if (edge_p) begin
               cnt_nxt = '0;
               sclk_nxt = ~sclk_r;
               edge_nxt = edge_r + 5'h01;
               if (shift_e) begin
                  // phase set: msb already out, so shift before presenting
                  if (pha_r) begin
                     if (edge_r != ssm_pkg::EDGES - 5'h01) begin
                        dout_nxt = tx_sh_r[W-2];
                        tx_sh_nxt = {tx_sh_r[W-2:0], 1'b0};
                     end
                  end else begin
                     dout_nxt = tx_sh_r[W-1];
                     tx_sh_nxt = {tx_sh_r[W-2:0], 1'b0};
                  end
               end
               if (latch_e) begin
                  rx_sh_nxt = {rx_sh_r[W-2:0], serial_data_in};
               end
               if (edge_r == ssm_pkg::EDGES - 5'h01) begin
                  state_nxt = ssm_pkg::SSM_DONE;
               end
            end
         end
         ssm_pkg::SSM_DONE: begin
            // hand the word to the buffer; start waits on its ready
            rx_push.valid = 1'b1;
            state_nxt = ssm_pkg::SSM_IDLE;
         end
         default: begin
            state_nxt = ssm_pkg::SSM_IDLE;
         end
      endcase
      // no new word while the buffer is full, so nothing is dropped
      tx_rdy_nxt = (state_r == ssm_pkg::SSM_IDLE) & ~start & rx_push.ready;
      // busy comes from its own flop so the pin never shows decode glitches
      busy_nxt = (state_nxt != ssm_pkg::SSM_IDLE);
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ssm_pkg::SSM_IDLE;
         div_r <= ssm_pkg::DIV_RST;
         cnt_r <= '0;
         edge_r <= '0;
         tx_sh_r <= ssm_pkg::WORD_RST;
         rx_sh_r <= ssm_pkg::WORD_RST;
         pha_r <= 1'b0;
         pol_r <= 1'b0;
         sclk_r <= 1'b0;
         dout_r <= 1'b0;
         tx_rdy_r <= 1'b0;
         clamp_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         edge_r <= edge_nxt;
         tx_sh_r <= tx_sh_nxt;
         rx_sh_r <= rx_sh_nxt;
         pha_r <= pha_nxt;
         pol_r <= pol_nxt;
         sclk_r <= sclk_nxt;
         dout_r <= dout_nxt;
         tx_rdy_r <= tx_rdy_nxt;
         clamp_r <= clamp_nxt;
         busy_r <= busy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer and outputs
   ////////////////////////////////////////////////////////////////////////////

   ssm_fifo2 u_rx_buf (
      .clock(clock),
      .sys_rst(sys_rst),
      .push(rx_push.snk),
      .pop(rx_pop.src)
   );

   assign rx_pop.ready = rx_ready;
   assign rx_data = rx_pop.data;
   assign rx_valid = rx_pop.valid;
   assign tx_ready = tx_rdy_r;
   assign serial_clk = sclk_r;
   assign serial_data_out = dout_r;
   assign busy = busy_r;
   assign rate_clamped = clamp_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////////////

   // cycles since the serial clock last moved, only for the period check
   logic [ssm_pkg::DIV_W-1:0] since_r, since_nxt;
   // restarts at every serial clock edge and outside a word
   always_comb begin
      since_nxt = (edge_p || state_r != ssm_pkg::SSM_RUN) ? '0 : since_r + 16'h0001;
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         since_r <= '0;
      end else begin
         since_r <= since_nxt;
      end
   end

   a_half_period_len: assert property (@(posedge clock) disable iff (sys_rst)
      edge_p |-> since_r == div_r)
      else $error("serial half period is not divider plus one cycles");
   a_div_follows: assert property (@(posedge clock) disable iff (sys_rst)
      start && baud_divider >= ssm_pkg::DIV_MIN |=> div_r == $past(baud_divider))
      else $error("divider not taken as programmed");
   a_rate_floor: assert property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_RUN |-> div_r >= ssm_pkg::DIV_MIN)
      else $error("serial period below the floor");
   a_shift_leading: assert property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_RUN && !pha_r && $changed(serial_data_out) |-> serial_clk != pol_r)
      else $error("data moved off the leading edge");
   a_idle_level: assert property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_IDLE && !clock_polarity_select |=> !serial_clk)
      else $error("clock not low when idle");
   a_edge_count: assert property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_DONE |-> edge_r == ssm_pkg::EDGES && serial_clk == pol_r)
      else $error("transfer did not use two edges per bit");
   a_latch_capture: assert property (@(posedge clock) disable iff (sys_rst)
      latch_e |=> rx_sh_r[0] == $past(serial_data_in) && serial_clk != $past(serial_clk))
      else $error("receive bit not captured on latch edge");

   c_word_pha0: cover property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_DONE && !pha_r);
   c_word_pha1_pol1: cover property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_DONE && pha_r && pol_r);
   c_stall: cover property (@(posedge clock) disable iff (sys_rst)
      state_r == ssm_pkg::SSM_IDLE && tx_valid && !rx_push.ready);
endmodule

// *** dv/ssm_slave_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// slave device on the far side of the serial link
module ssm_slave_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic busy,
   input wire logic serial_clk,
   input wire logic pha,
   input wire logic pol,
   input wire logic [7:0] word,
   output logic sdi
);
   logic prev_r;
   logic [4:0] cnt_r;
   logic [4:0] b;
   // index of the bit put out at the next shift edge
   assign b = pha ? ((cnt_r + 5'h01) >> 1) : (cnt_r >> 1);
   // no select line, so frames are told apart by the master's busy flag
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
         cnt_r <= 5'h00;
         sdi <= 1'b0;
      end else begin
         prev_r <= serial_clk;
         if (busy !== 1'b1) begin
            cnt_r <= 5'h00;
            // phase 1 needs bit 7 ready before the first edge; else a toggling line
            sdi <= pha ? word[7] : ~sdi;
         end else if (serial_clk != prev_r) begin
            cnt_r <= cnt_r + 5'h01;
            // shift edge: leading for phase 0, trailing for phase 1
            if ((serial_clk != pol) != pha) begin
               sdi <= (b < 5'h08) ? word[3'h7 - b[2:0]] : ~sdi;
            end
         end
      end
   end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic pha = 1'b0;
   logic pol = 1'b0;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic [15:0] div = 16'h0006;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] sw = 8'h00;
   logic tx_ready, rx_valid, serial_clk, sdo, sdi, busy, rate_clamped;
   logic [7:0] rx_data;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   // 100 MHz clock
   always #5 clock = ~clock;
   ssm_master u_dut (.clock(clock), .sys_rst(sys_rst), .baud_divider(div), .clock_phase_select(pha),
      .clock_polarity_select(pol), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .serial_clk(serial_clk),
      .serial_data_out(sdo), .serial_data_in(sdi), .busy(busy), .rate_clamped(rate_clamped));
   ssm_slave_model u_slv (.clock(clock), .sys_rst(sys_rst), .busy(busy), .serial_clk(serial_clk),
      .pha(pha), .pol(pol), .word(sw), .sdi(sdi));
   // hang guard: the slow-divider case alone needs about 66k cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // inputs always move 1 ns after the rising edge
   task tick;
      @(posedge clock);
      #1;
   endtask
   task automatic do_reset(logic ph, logic po);
      pha = ph;
      pol = po;
      sys_rst = 1'b1;
      tick;
      tick;
      sys_rst = 1'b0;
      tick;
      tick;
      check("idle_clk", serial_clk, po);
   endtask
   task automatic pop(logic [7:0] e);
      while (rx_valid !== 1'b1) tick;
      check("rx_data", rx_data, e);
      rx_ready = 1'b1;
      tick;
      rx_ready = 1'b0;
      tick;
   endtask
   // one word; every edge spacing, level and latched bit is judged
   task automatic xfer(logic [15:0] d, logic [7:0] tx, logic [7:0] rx, bit do_pop);
      int h;
      int gap;
      int k;
      logic last;
      h = ((d < 16'h0006) ? 6 : int'(d)) + 1;
      div = d;
      tx_data = tx;
      sw = rx;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) tick;
      tick;
      tx_valid = 1'b0;
      last = serial_clk;
      k = 0;
      gap = 0;
      while (k < 16) begin
         tick;
         gap++;
         if (serial_clk !== last) begin
            if (k > 0) check("half_period", gap, h);
            check("clk_level", serial_clk, pol ^ !k[0]);
            if (k[0] != pha) check("latched_bit", sdo, tx[7 - k / 2]);
            last = serial_clk;
            k++;
            gap = 0;
         end
      end
      while (busy === 1'b1) tick;
      check("clk_back_idle", serial_clk, pol);
      check("rate_clamped", rate_clamped, d < 16'h0006);
      if (do_pop) pop(rx);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // all four phase and polarity settings
   task t_modes;
      for (int i = 0; i < 4; i++) begin
         do_reset(i[0], i[1]);
         xfer(16'h0006, 8'h96 ^ 8'(i), 8'h4b + 8'(i), 1);
      end
   endtask
   // clamped, just above the floor, and a slower setting
   task t_rates;
      do_reset(1'b1, 1'b0);
      // divider one stays unused: the cpu clock here is above its limit
      xfer(16'h0002, 8'h81, 8'h7e, 1);
      xfer(16'h0007, 8'h01, 8'h80, 1);
      xfer(16'h0014, 8'hc6, 8'h39, 1);
   endtask
   // receiver stalls: buffer holds two words then refuses the third
   task t_stall;
      do_reset(1'b0, 1'b1);
      xfer(16'h0008, 8'ha5, 8'h3c, 0);
      xfer(16'h0008, 8'h5a, 8'hc3, 0);
      tx_data = 8'hff;
      tx_valid = 1'b1;
      repeat (30) tick;
      check("full_refuse", {tx_ready, busy}, 2'b00);
      tx_valid = 1'b0;
      pop(8'h3c);
      pop(8'hc3);
      check("drained", rx_valid, 1'b0);
   endtask
   // top divider: first edge only, then cut short by reset
   task t_slow;
      int gap;
      do_reset(1'b0, 1'b0);
      div = 16'hffff;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) tick;
      tick;
      tx_valid = 1'b0;
      gap = 0;
      while (serial_clk === 1'b0 && gap < 70000) begin
         tick;
         gap++;
      end
      check("slow_first_edge", gap, 32'h00010000);
      do_reset(1'b0, 1'b0);
   endtask
   initial begin
      t_modes;
      t_rates;
      t_stall;
      t_slow;
      tally_and_finish();
   end
endmodule
